// [hw/cssr_regs.sv]
// Purpose: socket identification/revision and interface status registers
// Assumes: byte host accesses, one access per cycle, same clock as host
// Notes:   status bits lag the pins by the synchroniser plus one flop
`timescale 1ns/100ps
`default_nettype none
module cssr_regs #(
  parameter logic [3:0] REV_DEFAULT = 4'h1, // arbitrary value, reset revision code
  parameter logic [3:0] REV_LEGACY  = 4'h3  // arbitrary value, older revision code
) (
  input  wire logic        sys_clk_i,             // host clock, 40 MHz
  input  wire logic        rst_b_i,               // async reset, active low
  input  wire logic [11:0] reg_addr_i,            // byte offset in socket space
  input  wire logic        reg_wr_i,              // write strobe, one cycle
  input  wire logic        reg_rd_i,              // read strobe, one cycle
  input  wire logic [7:0]  reg_wdata_i,           // write byte
  input  wire logic        subsystem_write_lock_i,// lock from system control
  input  wire logic        socket_power_on_i,     // vcc and vpp applied
  input  wire logic        card_ready_i,          // socket pin, async
  input  wire logic        card_wp_i,             // socket pin, async
  input  wire logic        card_cd1_b_i,          // socket pin, active low
  input  wire logic        card_cd2_b_i,          // socket pin, active low
  input  wire logic        card_bvd1_stschg_i,    // socket pin, async
  input  wire logic        card_bvd2_spkr_i,      // socket pin, async
  output logic [7:0]       reg_rdata_o,           // read byte, held
  output logic             legacy_compat_mode_o   // older controller mode
);
  // address decode, shared by read and write paths
  function automatic logic hit_id(input logic [11:0] a);
    hit_id = (a == cssr_pkg::ID_REV_OFFSET);
  endfunction : hit_id

  function automatic logic hit_status(input logic [11:0] a);
    hit_status = (a == cssr_pkg::IF_STATUS_OFFSET);
  endfunction : hit_status

  logic [5:0] id_rw_reg;       // bits 5:0 of the identification register
  logic [7:0] id_value;        // full identification byte as read
  logic [7:0] status_reg;      // sampled interface status
  logic [7:0] status_next;     // next status sample
  logic [7:0] rdata_reg;       // read data holding flop
  logic       legacy_reg;      // legacy compatibility mode flag
  logic       id_wr_ok;        // accepted write to identification

  // pins enter the bank through the synchroniser only
  cssr_pin_if #(.WIDTH(cssr_pkg::PIN_COUNT)) pin_bus ();

  assign pin_bus.raw[cssr_pkg::PIN_BVD1]  = card_bvd1_stschg_i;
  assign pin_bus.raw[cssr_pkg::PIN_BVD2]  = card_bvd2_spkr_i;
  assign pin_bus.raw[cssr_pkg::PIN_CD1_B] = card_cd1_b_i;
  assign pin_bus.raw[cssr_pkg::PIN_CD2_B] = card_cd2_b_i;
  assign pin_bus.raw[cssr_pkg::PIN_WP]    = card_wp_i;
  assign pin_bus.raw[cssr_pkg::PIN_READY] = card_ready_i;

  // metastability guard; costs two cycles of status latency
  cssr_pin_sync #(
    .WIDTH (cssr_pkg::PIN_COUNT)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pins      (pin_bus.sync)
  );

  // a write lands only when unlocked and aimed at the id register
  assign id_wr_ok = reg_wr_i && hit_id(reg_addr_i) && !subsystem_write_lock_i;

  // identification storage; top two bits are never stored
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      id_rw_reg <= {cssr_pkg::ID_RW_RESET[cssr_pkg::EMUL_MSB:cssr_pkg::EMUL_LSB],
                    REV_DEFAULT};
    end else if (id_wr_ok) begin
      id_rw_reg[cssr_pkg::EMUL_MSB:cssr_pkg::EMUL_LSB] <=
        reg_wdata_i[cssr_pkg::EMUL_MSB:cssr_pkg::EMUL_LSB];
      id_rw_reg[cssr_pkg::REV_MSB:cssr_pkg::REV_LSB] <=
        reg_wdata_i[cssr_pkg::REV_MSB:cssr_pkg::REV_LSB];
    end
  end

  // fixed type code on top, stored bits below
  assign id_value = {cssr_pkg::INTERFACE_TYPE, id_rw_reg};

  // legacy mode follows each accepted revision write
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      legacy_reg <= (REV_DEFAULT == REV_LEGACY);
    end else if (id_wr_ok) begin
      legacy_reg <= (reg_wdata_i[cssr_pkg::REV_MSB:cssr_pkg::REV_LSB] == REV_LEGACY);
    end
  end

  // status byte assembled from synced pins and power state
  always_comb begin
    status_next = cssr_pkg::STATUS_RESET;
    status_next[cssr_pkg::STAT_RSVD_BIT]  = 1'b0;
    status_next[cssr_pkg::STAT_POWER_BIT] = socket_power_on_i;
    status_next[cssr_pkg::STAT_READY_BIT] = pin_bus.synced[cssr_pkg::PIN_READY];
    status_next[cssr_pkg::STAT_WP_BIT]    = pin_bus.synced[cssr_pkg::PIN_WP];
    status_next[cssr_pkg::STAT_CDB_BIT]   = ~pin_bus.synced[cssr_pkg::PIN_CD2_B];
    status_next[cssr_pkg::STAT_CDA_BIT]   = ~pin_bus.synced[cssr_pkg::PIN_CD1_B];
    // same wires serve battery detect or speaker/status-change by card type
    status_next[cssr_pkg::STAT_BVD_MSB]   = pin_bus.synced[cssr_pkg::PIN_BVD2];
    status_next[cssr_pkg::STAT_BVD_LSB]   = pin_bus.synced[cssr_pkg::PIN_BVD1];
  end

  // status resamples every cycle; no write path reaches it
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_reg <= cssr_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // read data is captured on the read strobe and held until the next one
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= cssr_pkg::UNMAPPED_DATA;
    end else if (reg_rd_i) begin
      if (hit_id(reg_addr_i)) begin
        rdata_reg <= id_value;
      end else if (hit_status(reg_addr_i)) begin
        rdata_reg <= status_reg;
      end else begin
        // other offsets belong to other blocks; answer zero
        rdata_reg <= cssr_pkg::UNMAPPED_DATA;
      end
    end
  end

  assign reg_rdata_o          = rdata_reg;
  assign legacy_compat_mode_o = legacy_reg;

  // ---- assertions ----
  // type code always reads back fixed
  property p_type_code;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_id(reg_addr_i)) |=>
        (reg_rdata_o[cssr_pkg::TYPE_CODE_MSB:cssr_pkg::TYPE_CODE_LSB] ==
         cssr_pkg::INTERFACE_TYPE);
  endproperty
  a_type_code: assert property (p_type_code) else $error("interface type code wrong");

  // unlocked write then read returns the written low six bits
  property p_id_write;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (id_wr_ok ##1 (reg_rd_i && hit_id(reg_addr_i) && !reg_wr_i)) |=>
        (reg_rdata_o[5:0] == $past(reg_wdata_i[5:0], 2));
  endproperty
  a_id_write: assert property (p_id_write) else $error("id bits not stored");

  // revision default after reset
  property p_rev_default;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(rst_b_i) |-> (id_rw_reg[3:0] == REV_DEFAULT);
  endproperty
  a_rev_default: assert property (p_rev_default) else $error("revision default wrong");

  // older revision code switches mode next cycle
  property p_legacy;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      id_wr_ok |=> (legacy_compat_mode_o == ($past(reg_wdata_i[3:0]) == REV_LEGACY));
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy mode not updated");

  // locked writes leave identification untouched
  property p_lock;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_wr_i && hit_id(reg_addr_i) && subsystem_write_lock_i) |=>
        ($stable(id_rw_reg) && $stable(legacy_compat_mode_o));
  endproperty
  a_lock: assert property (p_lock) else $error("write lock ignored");

  // reserved status bit reads zero
  property p_stat_rsvd;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_status(reg_addr_i)) |=> !reg_rdata_o[cssr_pkg::STAT_RSVD_BIT];
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status bit 7 set");

  // power bit tracks power input two cycles back
  property p_power;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_status(reg_addr_i)) |=>
        (reg_rdata_o[cssr_pkg::STAT_POWER_BIT] == $past(socket_power_on_i, 2));
  endproperty
  a_power: assert property (p_power) else $error("power bit mismatch");

  // ready and write protect follow pins through sync and status flop
  property p_ready_wp;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_status(reg_addr_i) && $past(rst_b_i, 3)) |=>
        ((reg_rdata_o[cssr_pkg::STAT_READY_BIT] == $past(card_ready_i, 4)) &&
         (reg_rdata_o[cssr_pkg::STAT_WP_BIT] == $past(card_wp_i, 4)));
  endproperty
  a_ready_wp: assert property (p_ready_wp) else $error("ready or wp mismatch");

  // detect bits are pin inverted
  property p_detect;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_status(reg_addr_i) && $past(rst_b_i, 3)) |=>
        ((reg_rdata_o[cssr_pkg::STAT_CDB_BIT] == !$past(card_cd2_b_i, 4)) &&
         (reg_rdata_o[cssr_pkg::STAT_CDA_BIT] == !$past(card_cd1_b_i, 4)));
  endproperty
  a_detect: assert property (p_detect) else $error("card detect mismatch");

  // battery / speaker field mirrors pins in order
  property p_bvd;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_status(reg_addr_i) && $past(rst_b_i, 3)) |=>
        (reg_rdata_o[1:0] == {$past(card_bvd2_spkr_i, 4), $past(card_bvd1_stschg_i, 4)});
  endproperty
  a_bvd: assert property (p_bvd) else $error("battery field mismatch");

  // unmapped offsets read zero
  property p_unmapped;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_i && !hit_id(reg_addr_i) && !hit_status(reg_addr_i)) |=>
        (reg_rdata_o == cssr_pkg::UNMAPPED_DATA);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : cssr_regs
`default_nettype wire

// [inc/cssr_pkg.sv]
// Purpose: shared constants for the socket id and status register bank
// Assumes: byte-wide host register access at the socket register offsets
// Notes:   field positions and offsets are named here; the logic uses the names
package cssr_pkg;
  // register offsets inside the socket register space
  localparam logic [11:0] ID_REV_OFFSET     = 12'h800; // identification and revision
  localparam logic [11:0] IF_STATUS_OFFSET  = 12'h801; // interface status

  // identification register fields
  localparam int          TYPE_CODE_MSB     = 7;       // interface_type_code top bit
  localparam int          TYPE_CODE_LSB     = 6;       // interface_type_code low bit
  localparam logic [1:0]  INTERFACE_TYPE    = 2'h2;    // both io and memory cards
  localparam int          EMUL_MSB          = 5;       // emulation scratch bits
  localparam int          EMUL_LSB          = 4;
  localparam int          REV_MSB           = 3;       // compat_revision_field
  localparam int          REV_LSB           = 0;
  localparam logic [5:0]  ID_RW_RESET       = 6'h00;   // emulation bits reset value

  // interface status register fields
  localparam int          STAT_RSVD_BIT     = 7;       // always reads zero
  localparam int          STAT_POWER_BIT    = 6;       // socket_power_on_flag
  localparam int          STAT_READY_BIT    = 5;       // card ready
  localparam int          STAT_WP_BIT       = 4;       // card_write_protect_flag
  localparam int          STAT_CDB_BIT      = 3;       // card_detect_b_flag
  localparam int          STAT_CDA_BIT      = 2;       // card_detect_a_flag
  localparam int          STAT_BVD_MSB      = 1;       // battery_detect_field top
  localparam int          STAT_BVD_LSB      = 0;       // battery_detect_field low
  localparam logic [7:0]  STATUS_RESET      = 8'h00;   // before pins are sampled

  // socket pin vector layout handed to the synchroniser
  localparam int          PIN_COUNT         = 6;
  localparam int          PIN_BVD1          = 0;       // bvd1 or stschg
  localparam int          PIN_BVD2          = 1;       // bvd2 or spkr
  localparam int          PIN_CD1_B         = 2;       // card detect a, active low
  localparam int          PIN_CD2_B         = 3;       // card detect b, active low
  localparam int          PIN_WP            = 4;       // write protect
  localparam int          PIN_READY         = 5;       // card ready

  localparam logic [7:0]  UNMAPPED_DATA     = 8'h00;   // answer to other offsets
endpackage : cssr_pkg

// [inc/cssr_pin_if.sv]
// Purpose: carries raw socket pins into the synchroniser and back out
// Assumes: one host clock domain on the synchronised side
// Notes:   raw side is asynchronous; synced side is safe to read
`timescale 1ns/100ps
`default_nettype none
interface cssr_pin_if #(
  parameter int WIDTH = 6
);
  logic [WIDTH-1:0] raw;     // straight from the socket pins
  logic [WIDTH-1:0] synced;  // after two host clock flops

  // register bank drives pins in, reads synced values
  modport bank (output raw, input synced);
  // synchroniser reads raw, drives synced
  modport sync (input raw, output synced);
endinterface : cssr_pin_if
`default_nettype wire

// [hw/cssr_pin_sync.sv]
// Purpose: two-flop synchroniser for the socket status pins
// Assumes: pins change slowly compared with the host clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module cssr_pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic sys_clk_i,  // host clock
  input  wire logic rst_b_i,    // async reset, active low
  cssr_pin_if.sync  pins        // raw in, synced out
);
  logic [WIDTH-1:0] meta_reg;   // first stage, may go metastable
  logic [WIDTH-1:0] stable_reg; // second stage, safe for logic

  // one pair of flops per pin; no shared logic between bits
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_reg[gi]   <= 1'b0;
          stable_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi]   <= pins.raw[gi];
          stable_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign pins.synced = stable_reg;
endmodule : cssr_pin_sync
`default_nettype wire

// [verif/cssr_card_model.sv]
// Purpose: behavioural 16-bit card seated in the socket, memory or io kind
// Assumes: the bench sets contact and signal levels; no handshake on these pins
// Notes:   with no detect contact made, signal pins float and wander each cycle
`timescale 1ns/100ps
`default_nettype none
module cssr_card_model (
  input  wire logic       sys_clk_i, // paces the floating pattern only
  input  wire logic [1:0] seat_i,    // contacts made: bit 1 detect b, bit 0 detect a
  input  wire logic [3:0] lvl_i,     // ready, wp, bvd2 or spkr, bvd1 or stschg
  output logic            ready_o,   // card ready level
  output logic            wp_o,      // write protect level
  output logic            cd1_b_o,   // detect a, pulled up when open
  output logic            cd2_b_o,   // detect b, pulled up when open
  output logic            bvd1_o,    // bvd1 or stschg
  output logic            bvd2_o     // bvd2 or spkr
);
  logic [3:0] float_reg = 4'h5;      // toggling, so a stale level never reads as real
  // floating lines change every cycle
  always_ff @(posedge sys_clk_i) begin
    float_reg <= ~float_reg;
  end
  // detect pins are grounded by the card, pulled high otherwise
  assign cd1_b_o = ~seat_i[0];
  assign cd2_b_o = ~seat_i[1];
  // a card with any contact made drives its signal pins
  assign {ready_o, wp_o, bvd2_o, bvd1_o} = (|seat_i) ? lvl_i : float_reg;
endmodule : cssr_card_model
`default_nettype wire

// [verif/card_socket_id_and_status_regs_tb.sv]
// Purpose: self-checking bench for the socket id and status registers
// Assumes: byte strobes of one cycle, read data held until the next read
// Notes:   pin levels are settled for six cycles before each status read
`timescale 1ns/100ps
`default_nettype none
module card_socket_id_and_status_regs_tb;
  localparam logic [3:0] REV_DEF = 4'h6;       // arbitrary value, reset revision
  localparam logic [3:0] REV_OLD = 4'h9;       // arbitrary value, older revision
  logic        sys_clk, rst_b, reg_wr, reg_rd;  // clock, reset, strobes
  logic [11:0] reg_addr;                        // byte offset
  logic [7:0]  reg_wdata, rdata, rv, d, m;      // data and masks
  logic        wr_lock, pwr_on, legacy, lk;     // lock, power, mode
  logic [1:0]  seat;                            // detect contacts made
  logic [3:0]  lvl;                             // card signal levels
  logic        ready, wp, cd1_b, cd2_b, bvd1, bvd2; // socket pins
  logic [5:0]  exp_id;                          // expected writable id bits
  logic        exp_leg;                         // expected legacy mode
  int          mismatches = 0;
  int          cmp_count = 0;
  integer      seed = 32'hea3924f4;
  cssr_card_model card (.sys_clk_i(sys_clk), .seat_i(seat), .lvl_i(lvl), .ready_o(ready),
    .wp_o(wp), .cd1_b_o(cd1_b), .cd2_b_o(cd2_b), .bvd1_o(bvd1), .bvd2_o(bvd2));
  cssr_regs #(.REV_DEFAULT(REV_DEF), .REV_LEGACY(REV_OLD)) uut (.sys_clk_i(sys_clk),
    .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .subsystem_write_lock_i(wr_lock), .socket_power_on_i(pwr_on),
    .card_ready_i(ready), .card_wp_i(wp), .card_cd1_b_i(cd1_b), .card_cd2_b_i(cd2_b),
    .card_bvd1_stschg_i(bvd1), .card_bvd2_spkr_i(bvd2), .reg_rdata_o(rdata),
    .legacy_compat_mode_o(legacy));
  // expected status byte from what the card presents
  function automatic logic [7:0] exp_status(input logic p, input logic [1:0] s,
                                            input logic [3:0] l);
    return {1'b0, p, l[3], l[2], s[1], s[0], l[1], l[0]};
  endfunction : exp_status
  // one comparison, counted; case inequality so unknowns fail
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : chk
  // write strobe held across exactly one taking edge
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
    @(posedge sys_clk); #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk); #1;
    reg_wr = 1'b0;
  endtask : wr_reg
  // read strobe for one edge, data taken once it stands
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
    @(posedge sys_clk); #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk); #1;
    reg_rd = 1'b0;
    @(posedge sys_clk); #1;
    v = rdata;
  endtask : rd_reg
  // write then read in the very next cycle; data taken once it stands
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge sys_clk); #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk); #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge sys_clk); #1;
    reg_rd = 1'b0;
    r = rdata;
  endtask : wr_rd
  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // free-running 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #250000;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, wr_lock, pwr_on} = '0;
    seat = 2'h3;
    lvl = 4'ha;
    repeat (20) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int r = 0; r < 2; r++) begin
      // reset values; second pass follows a mid-run reset after legacy writes
      rd_reg(cssr_pkg::ID_REV_OFFSET, rv);
      chk("id after reset", rv, {2'h2, 2'h0, REV_DEF});
      chk("legacy after reset", {7'h0, legacy}, 8'h00);
      rd_reg(cssr_pkg::IF_STATUS_OFFSET, rv);
      chk("status after reset", rv, exp_status(1'b0, seat, lvl));
      $display("test reset pass %0d done", r);
      exp_id = {2'h0, REV_DEF};
      exp_leg = 1'b0;
      // id writes: legacy entry, locked write, then random with many legacy codes
      for (int i = 0; i < 24; i++) begin
        d = 8'($random(seed));
        lk = 1'($random(seed));
        if (i == 0) {lk, d} = {1'b0, 2'h1, 2'h3, REV_OLD};
        if (i == 1) {lk, d} = 9'h100;
        if (d[6]) d[3:0] = REV_OLD;
        wr_lock = lk;
        // odd passes read back in the cycle right after the write
        if (i[0]) begin
          wr_rd(cssr_pkg::ID_REV_OFFSET, d, rv);
        end else begin
          wr_reg(cssr_pkg::ID_REV_OFFSET, d);
          rd_reg(cssr_pkg::ID_REV_OFFSET, rv);
        end
        if (!lk) begin
          exp_id = d[5:0];
          exp_leg = (d[3:0] == REV_OLD);
        end
        chk("id readback", rv, {2'h2, exp_id});
        chk("legacy mode", {7'h0, legacy}, {7'h0, exp_leg});
      end
      $display("test id writes done");
      if (r == 0) begin
        wr_lock = 1'b0;
        wr_reg(cssr_pkg::ID_REV_OFFSET, {4'h0, REV_OLD});
        rst_b = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
      end
    end
    // unmapped place: read answers zero, write leaves id alone even unlocked
    wr_lock = 1'b0;
    wr_reg(12'h7ff, 8'h3f);
    rd_reg(12'h802, rv);
    chk("unmapped read", rv, cssr_pkg::UNMAPPED_DATA);
    rd_reg(cssr_pkg::ID_REV_OFFSET, rv);
    chk("id after stray write", rv, {2'h2, exp_id});
    $display("test unmapped done");
    // status: every contact pattern, then random cards of either kind
    for (int i = 0; i < 24; i++) begin
      seat = (i < 4) ? 2'(i) : 2'($random(seed));
      lvl = 4'($random(seed));
      pwr_on = 1'($random(seed));
      repeat (6) @(posedge sys_clk);
      wr_reg(cssr_pkg::IF_STATUS_OFFSET, 8'hff);
      rd_reg(cssr_pkg::IF_STATUS_OFFSET, rv);
      // no contact: ready, wp and both battery lines float, so mask them all
      m = (seat == 2'h0) ? 8'hcc : 8'hff;
      chk("status", rv & m, exp_status(pwr_on, seat, lvl) & m);
      chk("fully seated", {7'h0, &rv[3:2]}, {7'h0, seat == 2'h3});
    end
    $display("test status done");
    report_and_stop();
  end
endmodule : card_socket_id_and_status_regs_tb
`default_nettype wire
